// ### design/mtc_axil_regs.sv
// AXI4-Lite slave holding the transmit configuration and status registers
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.svh"
module mtc_axil_regs
   import mtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   mtc_cfg_if.regs cfg
);
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic [31:0] transmit_configuration;
   logic [31:0] byteMask;
   logic doWrite;

   assign cfg.cfgWord = transmit_configuration;
   assign doWrite = awHeld && wHeld && !bvalid;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byteMask[i*8 +: 8] = {8{wStrbHeld[i]}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channels: address and data are taken in either order
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         awAddrHeld <= 8'h00;
         wDataHeld <= 32'h00000000;
         wStrbHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else begin
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awready <= 1'b0;
            awAddrHeld <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wready <= 1'b0;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (awAddrHeld[7:2] == `MTC_ADDR_TRANSMIT_CONFIGURATION >> 2 ||
                      awAddrHeld[7:2] == `MTC_ADDR_STATUS >> 2) ? 2'b00 : 2'b10;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         transmit_configuration <= `MTC_TRANSMIT_CONFIGURATION_RESET;
      end else if (doWrite && awAddrHeld[7:2] == `MTC_ADDR_TRANSMIT_CONFIGURATION >> 2) begin
         // Reserved and unused bits are dropped here so they always read zero
         transmit_configuration <= ((transmit_configuration & ~byteMask) | (wDataHeld & byteMask)) & `MTC_TRANSMIT_CONFIGURATION_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         if (araddr[7:2] == `MTC_ADDR_TRANSMIT_CONFIGURATION >> 2) begin
            rdata <= transmit_configuration;
            rresp <= 2'b00;
         end else if (araddr[7:2] == `MTC_ADDR_STATUS >> 2) begin
            rdata <= cfg.statusWord;
            rresp <= 2'b00;
         end else begin
            rdata <= 32'h00000000;
            rresp <= 2'b10;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
      rvalid |-> rdata[25:24] == 2'b00)
      else $error("reserved bits read non-zero");
endmodule
`default_nettype wire

// ### design/mtc_tx_ctrl.sv
// Transmit configuration control: register access, frame gap, padding, retry and link monitors
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.svh"
// Summary of operation
// - Carrier sense ignore set: carrier activity is not reported in transmit status.
// - Carrier sense ignore clear: carrier watched during transmission, loss reported in transmit status.
// - Heartbeat ignore set: post-frame heartbeat is ignored, no signal quality errors counted.
// - Heartbeat ignore clear: missing heartbeat after a frame bumps the error count.
// - Loopback set: frames go to own receiver, both media interface sides disabled.
// - Frames received in loopback carry the loopback flag in their status.
// - Auto padding set: frames shorter than 64 bytes are extended to 64.
// - Auto padding clear: short frames are sent at their own length.
// - At 10 Mb/s the gap is 9.6 us minus 0.4 us per field step.
// - At 100 Mb/s the gap is 960 ns minus 40 ns per field step.
// - Bits 25 and 24 ignore writes and read as zero.
// - Retry enabled: up to 64 attempts, abort when the 64th fails.
// - Retry disabled: abort after the 16th failed attempt.
// - Retry enable changes how the collision count is reported.
module mtc_tx_ctrl
   import mtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic speed100,
   input wire logic frameReq,
   input wire logic [10:0] frameLen,
   input wire logic txEnd,
   input wire logic miiCrs,
   input wire logic miiCol,
   output logic txBusy,
   output logic txGo,
   output logic [10:0] txSendLen,
   output logic txDoneValid,
   output logic txAborted,
   output logic txCarrierLost,
   output logic [6:0] txCollisions,
   output logic sqeErrorPulse,
   output logic [15:0] sqe_error_count,
   output logic miiTxEnable,
   output logic miiRxEnable,
   output logic loopback_received_flag
);
   mtc_cfg_if cfgBus();
   mtc_state_e state;
   logic [1:0] pinMeta;
   logic [1:0] pinSync;
   logic crsSync;
   logic colSync;
   logic loopActive;
   logic snapCsi;
   logic snapHbi;
   logic snapPad;
   logic snapEcr;
   logic snapSpeed;
   logic [1:0] snapIfg;
   logic [10:0] lenSnap;
   logic [10:0] gapCnt;
   logic [10:0] gapElapsed;
   logic [10:0] gapTarget;
   logic [6:0] attemptCnt;
   logic [6:0] tryLimit;
   logic [11:0] hbCnt;
   logic hbSeen;
   logic carrierSeen;
   logic collNow;
   logic lastFail;
   logic [3:0] xmitAge;

   mtc_axil_regs u_regs (
      .clk_sys(clk_sys),
      .rst(rst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .cfg(cfgBus.regs)
   );

   assign cfgBus.statusWord = {txBusy, txAborted, txCarrierLost, loopActive, 5'h00,
                               txCollisions, sqe_error_count};

   ////////////////////////////////////////////////////////////////////////
   // Media pins come from the transceiver's clock, so two flops first
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pinMeta <= 2'b00;
         pinSync <= 2'b00;
      end else begin
         pinMeta <= {miiCol, miiCrs};
         pinSync <= pinMeta;
      end
   end
   // In loopback the media interface is off, so its pins mean nothing
   assign crsSync = pinSync[0] && !loopActive;
   assign colSync = pinSync[1] && !loopActive;

   function automatic logic [10:0] gapCycles(input logic fast, input logic [1:0] trim);
      if (fast) begin
         gapCycles = 11'(`MTC_IFG100_CNT - `MTC_STEP100_CNT * trim);
      end else begin
         gapCycles = 11'(`MTC_IFG10_CNT - `MTC_STEP10_CNT * trim);
      end
   endfunction

   assign gapTarget = gapCycles(snapSpeed, snapIfg);
   assign tryLimit = snapEcr ? 7'(`MTC_TRIES_RETRY) : 7'(`MTC_TRIES_NORMAL);
   assign collNow = (state == MTC_XMIT) && colSync;
   assign lastFail = collNow && (attemptCnt + 7'd1 == tryLimit);

   ////////////////////////////////////////////////////////////////////////
   // Settings are captured only between frames
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         snapCsi <= 1'b0;
         snapHbi <= 1'b0;
         snapPad <= 1'b0;
         snapEcr <= 1'b0;
         snapSpeed <= 1'b0;
         snapIfg <= 2'b00;
         lenSnap <= 11'h000;
         loopActive <= 1'b0;
         miiTxEnable <= 1'b1;
         miiRxEnable <= 1'b1;
         loopback_received_flag <= 1'b0;
      end else if (state == MTC_IDLE) begin
         loopActive <= cfgBus.cfgWord[`MTC_BIT_MLB];
         miiTxEnable <= !cfgBus.cfgWord[`MTC_BIT_MLB];
         miiRxEnable <= !cfgBus.cfgWord[`MTC_BIT_MLB];
         loopback_received_flag <= cfgBus.cfgWord[`MTC_BIT_MLB];
         if (frameReq) begin
            snapCsi <= cfgBus.cfgWord[`MTC_BIT_CSI];
            snapHbi <= cfgBus.cfgWord[`MTC_BIT_HBI];
            snapPad <= cfgBus.cfgWord[`MTC_BIT_PAD];
            snapEcr <= cfgBus.cfgWord[`MTC_BIT_ECR];
            snapIfg <= cfgBus.cfgWord[`MTC_IFG_HI:`MTC_IFG_LO];
            snapSpeed <= speed100;
            lenSnap <= frameLen;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= MTC_IDLE;
         gapCnt <= 11'h000;
         hbCnt <= 12'h000;
         attemptCnt <= 7'h00;
      end else begin
         unique case (state)
            MTC_IDLE: begin
               attemptCnt <= 7'h00;
               if (frameReq) begin
                  state <= MTC_GAP;
                  gapCnt <= gapCycles(speed100, cfgBus.cfgWord[`MTC_IFG_HI:`MTC_IFG_LO]) - 11'd1;
               end
            end
            MTC_GAP: begin
               if (gapCnt == 11'h000) begin
                  state <= MTC_XMIT;
               end else begin
                  gapCnt <= gapCnt - 11'd1;
               end
            end
            MTC_XMIT: begin
               if (collNow) begin
                  attemptCnt <= attemptCnt + 7'd1;
                  if (lastFail) begin
                     state <= MTC_DONE;
                  end else begin
                     // Retry waits a full gap again; backoff is the sender's job
                     state <= MTC_GAP;
                     gapCnt <= gapTarget - 11'd1;
                  end
               end else if (txEnd) begin
                  state <= MTC_HBEAT;
                  hbCnt <= 12'(`MTC_HBWIN_CNT - 1);
               end
            end
            MTC_HBEAT: begin
               if (hbCnt == 12'h000) begin
                  state <= MTC_DONE;
               end else begin
                  hbCnt <= hbCnt - 12'd1;
               end
            end
            MTC_DONE: begin
               state <= MTC_IDLE;
            end
            default: begin
               state <= MTC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Carrier needs the pin latency and the transceiver's turnaround before it can show
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         xmitAge <= 4'h0;
      end else begin
         xmitAge <= {xmitAge[2:0], state == MTC_XMIT};
      end
   end

   // Carrier and heartbeat monitors
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         carrierSeen <= 1'b0;
         hbSeen <= 1'b0;
      end else if (state == MTC_IDLE) begin
         carrierSeen <= 1'b0;
         hbSeen <= 1'b0;
      end else begin
         if (state == MTC_XMIT && xmitAge[3] && !snapCsi && !crsSync && !loopActive) begin
            carrierSeen <= 1'b1;
         end
         if (state == MTC_HBEAT && colSync) begin
            hbSeen <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs toward the byte engine and descriptor status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txBusy <= 1'b0;
         txGo <= 1'b0;
         txSendLen <= 11'h000;
         txDoneValid <= 1'b0;
         txAborted <= 1'b0;
         txCarrierLost <= 1'b0;
         txCollisions <= 7'h00;
      end else begin
         txBusy <= (state != MTC_IDLE) || frameReq;
         txGo <= (state == MTC_GAP) && (gapCnt == 11'h000);
         if (state == MTC_GAP) begin
            if (snapPad && lenSnap < 11'(`MTC_MIN_FRAME)) begin
               txSendLen <= 11'(`MTC_MIN_FRAME);
            end else begin
               txSendLen <= lenSnap;
            end
         end
         txDoneValid <= (state == MTC_DONE);
         if (state == MTC_DONE) begin
            txAborted <= (attemptCnt == tryLimit);
            txCarrierLost <= carrierSeen && !snapCsi;
            // Plain mode saturates at 15; retry mode reports the whole count
            if (snapEcr) begin
               txCollisions <= attemptCnt;
            end else begin
               txCollisions <= (attemptCnt > 7'd15) ? 7'd15 : attemptCnt;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sqeErrorPulse <= 1'b0;
         sqe_error_count <= 16'h0000;
      end else begin
         sqeErrorPulse <= 1'b0;
         if (state == MTC_HBEAT && hbCnt == 12'h000 && !hbSeen && !colSync &&
             !snapHbi && !loopActive) begin
            sqeErrorPulse <= 1'b1;
            if (sqe_error_count != 16'hffff) begin
               sqe_error_count <= sqe_error_count + 16'd1;
            end
         end
      end
   end

   // Helper for checking the gap length
   always_ff @(posedge clk_sys) begin
      if (rst || state != MTC_GAP) begin
         gapElapsed <= 11'h000;
      end else begin
         gapElapsed <= gapElapsed + 11'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_hb_missing;
      state == MTC_HBEAT && hbCnt == 12'h000 && !hbSeen && !colSync && !snapHbi && !loopActive;
   endsequence

   sequence s_sqe_logged;
      sqeErrorPulse && sqe_error_count != $past(sqe_error_count);
   endsequence

   a_csi_no_report: assert property (@(posedge clk_sys) disable iff (rst)
      txDoneValid && snapCsi |-> !txCarrierLost)
      else $error("carrier loss reported while ignored");

   a_crs_loss_seen: assert property (@(posedge clk_sys) disable iff (rst)
      state == MTC_XMIT && xmitAge[3] && !snapCsi && !crsSync && !loopActive |=> carrierSeen)
      else $error("carrier loss not recorded");

   a_hbi_no_sqe: assert property (@(posedge clk_sys) disable iff (rst)
      sqeErrorPulse |-> !snapHbi)
      else $error("sqe error logged while heartbeat ignored");

   a_sqe_on_missing: assert property (@(posedge clk_sys) disable iff (rst)
      s_hb_missing |=> s_sqe_logged ##1 !sqeErrorPulse)
      else $error("missing heartbeat not counted");

   a_loop_mii_off: assert property (@(posedge clk_sys) disable iff (rst)
      loopActive |-> !miiTxEnable && !miiRxEnable && loopback_received_flag)
      else $error("media interface active in loopback");

   a_pad_length: assert property (@(posedge clk_sys) disable iff (rst)
      txGo && snapPad |-> txSendLen >= 11'd64 && txSendLen >= lenSnap)
      else $error("short frame not padded");

   a_no_pad: assert property (@(posedge clk_sys) disable iff (rst)
      txGo && !snapPad |-> txSendLen == lenSnap)
      else $error("frame padded while padding off");

   a_gap_exact: assert property (@(posedge clk_sys) disable iff (rst)
      state == MTC_GAP && gapCnt == 11'h000 |-> gapElapsed == gapTarget - 11'd1)
      else $error("interframe gap length wrong");

   a_abort_limit: assert property (@(posedge clk_sys) disable iff (rst)
      lastFail |=> state == MTC_DONE ##1 txDoneValid && txAborted)
      else $error("abort not at attempt limit");

   a_cfg_frozen: assert property (@(posedge clk_sys) disable iff (rst)
      state != MTC_IDLE && $past(state) != MTC_IDLE |->
         $stable(snapIfg) && $stable(snapEcr) && $stable(loopActive))
      else $error("settings changed mid frame");
endmodule
`default_nettype wire

// ### pkg/mtc_cfg_if.sv
// Configuration and status carried between register slave and transmit core
`timescale 1ns/1ps
`default_nettype none
interface mtc_cfg_if;
   logic [31:0] cfgWord;
   logic [31:0] statusWord;
   modport regs(output cfgWord, input statusWord);
   modport core(input cfgWord, output statusWord);
endinterface
`default_nettype wire

// ### pkg/mtc_defs.svh
// Offsets, field positions, reset values and timing counts of the transmit configuration block
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH

`define MTC_ADDR_TRANSMIT_CONFIGURATION 8'h24
`define MTC_ADDR_STATUS 8'h28

`define MTC_TRANSMIT_CONFIGURATION_RESET 32'h00000102
// Reserved 25-24 and unused 19-14, 7-6 never store
`define MTC_TRANSMIT_CONFIGURATION_WMASK 32'hfcf03f3f

`define MTC_BIT_CSI 31
`define MTC_BIT_HBI 30
`define MTC_BIT_MLB 29
`define MTC_BIT_PAD 28
`define MTC_IFG_HI 27
`define MTC_IFG_LO 26
`define MTC_BIT_ECR 23

`define MTC_ST_BUSY 31
`define MTC_ST_ABORT 30
`define MTC_ST_CRSLOST 29
`define MTC_ST_LOOP 28
`define MTC_ST_COLL_HI 22
`define MTC_ST_COLL_LO 16

`define MTC_CLK_NS 5
`define MTC_IFG10_NS 9600
`define MTC_STEP10_NS 400
`define MTC_IFG100_NS 960
`define MTC_STEP100_NS 40
`define MTC_HBWIN_NS 4000
`define MTC_IFG10_CNT (`MTC_IFG10_NS / `MTC_CLK_NS)
`define MTC_STEP10_CNT (`MTC_STEP10_NS / `MTC_CLK_NS)
`define MTC_IFG100_CNT (`MTC_IFG100_NS / `MTC_CLK_NS)
`define MTC_STEP100_CNT (`MTC_STEP100_NS / `MTC_CLK_NS)
`define MTC_HBWIN_CNT (`MTC_HBWIN_NS / `MTC_CLK_NS)

`define MTC_MIN_FRAME 64
`define MTC_TRIES_NORMAL 16
`define MTC_TRIES_RETRY 64

`endif

// ### pkg/mtc_pkg.sv
// Types shared by the transmit configuration block
package mtc_pkg;
   typedef enum logic [2:0] {
      MTC_IDLE = 3'b000,
      MTC_GAP = 3'b001,
      MTC_XMIT = 3'b011,
      MTC_HBEAT = 3'b010,
      MTC_DONE = 3'b110
   } mtc_state_e;
endpackage

// ### testbench/mac_tx_config_control_tb.sv
// Self-checking bench for the transmit configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defs.svh"
module mac_tx_config_control_tb;
   import mtc_pkg::*;
   logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, speed100, frameReq, txEnd, miiCrs, miiCol;
   logic txBusy, txGo, txDoneValid, txAborted, txCarrierLost, sqeErrorPulse;
   logic miiTxEnable, miiRxEnable, loopback_received_flag, collide, dropCrs, heartbeat;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [10:0] frameLen, txSendLen;
   logic [6:0] txCollisions;
   logic [15:0] sqe_error_count;
   int failures, n_checks, cyc, gos;
   mtc_tx_ctrl mtc_tx_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .speed100(speed100), .frameReq(frameReq), .frameLen(frameLen),
      .txEnd(txEnd), .miiCrs(miiCrs), .miiCol(miiCol), .txBusy(txBusy), .txGo(txGo),
      .txSendLen(txSendLen), .txDoneValid(txDoneValid), .txAborted(txAborted),
      .txCarrierLost(txCarrierLost), .txCollisions(txCollisions),
      .sqeErrorPulse(sqeErrorPulse), .sqe_error_count(sqe_error_count),
      .miiTxEnable(miiTxEnable), .miiRxEnable(miiRxEnable),
      .loopback_received_flag(loopback_received_flag));
   mtc_phy_model mtc_phy_model_inst (.clk_sys(clk_sys), .txGo(txGo), .collide(collide),
      .dropCrs(dropCrs), .heartbeat(heartbeat), .txEnd(txEnd), .miiCrs(miiCrs),
      .miiCol(miiCol));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = !clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   // Outputs are read right after the edge, so they show what that edge sampled
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      bready <= 1'b0;
      r = bresp;
   endtask
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   // txGo is launched at the last gap edge and is read one edge later
   task frame(input logic [10:0] len, input logic spd, input logic mid, input int gap,
         input logic [10:0] sendLen);
      int t0;
      logic [1:0] r;
      @(posedge clk_sys);
      frameReq <= 1'b1;
      frameLen <= len;
      speed100 <= spd;
      @(posedge clk_sys);
      frameReq <= 1'b0;
      t0 = cyc;
      if (mid) axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'h00000000, r);
      while (txGo !== 1'b1) @(posedge clk_sys);
      chk("gap", 32'(gap + 1), 32'(cyc - t0));
      chk("busy", 32'h1, 32'(txBusy));
      chk("sendLen", 32'(sendLen), 32'(txSendLen));
      gos = 1;
      while (txDoneValid !== 1'b1) begin
         @(posedge clk_sys);
         if (txGo === 1'b1) gos++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axr(`MTC_ADDR_TRANSMIT_CONFIGURATION, d, r);
      chk("resetCfg", `MTC_TRANSMIT_CONFIGURATION_RESET, d);
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'hffffffff, r);
      axr(`MTC_ADDR_TRANSMIT_CONFIGURATION, d, r);
      chk("reservedBits", `MTC_TRANSMIT_CONFIGURATION_WMASK, d);
      axw(8'h40, 32'h12345678, r);
      chk("unmappedWrite", 32'h2, 32'(r));
      axr(8'h40, d, r);
      chk("unmappedRead", 32'h2, 32'(r));
   endtask
   task t_pad;
      logic [1:0] r;
      dropCrs <= 1'b1;
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'hdc000000, r);
      frame(11'd63, 1'b1, 1'b1, 192 - 8 * 3, 11'd64);
      chk("lostIgnored", 32'h0, 32'(txCarrierLost));
      chk("sqeIgnored", 32'h0, 32'(sqe_error_count));
   endtask
   task t_nopad;
      logic [1:0] r;
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'h08000000, r);
      frame(11'd40, 1'b0, 1'b0, 1920 - 80 * 2, 11'd40);
      chk("lostSeen", 32'h1, 32'(txCarrierLost));
      chk("sqeCount", 32'h1, 32'(sqe_error_count));
      dropCrs <= 1'b0;
      heartbeat <= 1'b1;
      frame(11'd64, 1'b1, 1'b0, 192 - 8 * 2, 11'd64);
      chk("sqeHeld", 32'h1, 32'(sqe_error_count));
      chk("lostClear", 32'h0, 32'(txCarrierLost));
      heartbeat <= 1'b0;
   endtask
   task t_retry(input logic [31:0] cfg, input int tries, input int colls);
      logic [1:0] r;
      logic [31:0] d;
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, cfg, r);
      collide <= 1'b1;
      frame(11'd100, 1'b1, 1'b0, 192, 11'd100);
      collide <= 1'b0;
      chk("attempts", 32'(tries), 32'(gos));
      chk("aborted", 32'h1, 32'(txAborted));
      chk("collisions", 32'(colls), 32'(txCollisions));
      axr(`MTC_ADDR_STATUS, d, r);
      chk("status", 32'h40000001 | (32'(colls) << 16), d);
   endtask
   task t_loop;
      logic [1:0] r;
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'he0000000, r);
      repeat (3) @(posedge clk_sys);
      chk("loopTx", 32'h0, 32'({miiTxEnable, miiRxEnable}));
      chk("loopFlag", 32'h1, 32'(loopback_received_flag));
      axw(`MTC_ADDR_TRANSMIT_CONFIGURATION, 32'hc0000000, r);
      repeat (3) @(posedge clk_sys);
      chk("loopOff", 32'h6, 32'({miiTxEnable, miiRxEnable, loopback_received_flag}));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready, speed100, frameReq} = 8'hff;
      {awvalid, wvalid, bready, arvalid, rready, speed100, frameReq} = 7'h00;
      {collide, dropCrs, heartbeat} = 3'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'hf;
      frameLen = 11'd0;
      failures = 0;
      n_checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_loop();
      t_pad();
      t_nopad();
      t_retry(32'hc0000000, `MTC_TRIES_NORMAL, 15);
      t_retry(32'hc0800000, `MTC_TRIES_RETRY, 64);
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire

// ### testbench/mtc_phy_model.sv
// Behavioural line partner: carrier, collision and heartbeat around each transmit attempt
`timescale 1ns/1ps
`default_nettype none
module mtc_phy_model (
   input wire logic clk_sys,
   input wire logic txGo,
   input wire logic collide,
   input wire logic dropCrs,
   input wire logic heartbeat,
   output logic txEnd,
   output logic miiCrs,
   output logic miiCol
);
   initial begin
      txEnd = 1'b0;
      miiCrs = 1'b0;
      miiCol = 1'b0;
   end
   // Carrier is a level only while an attempt is on the wire
   always begin
      @(posedge clk_sys);
      if (txGo) begin
         miiCrs <= !dropCrs;
         repeat (4) @(posedge clk_sys);
         if (collide) begin
            miiCol <= 1'b1;
            repeat (3) @(posedge clk_sys);
            miiCol <= 1'b0;
            miiCrs <= 1'b0;
         end else begin
            repeat (20) @(posedge clk_sys);
            txEnd <= 1'b1;
            @(posedge clk_sys);
            txEnd <= 1'b0;
            miiCrs <= 1'b0;
            if (heartbeat) begin
               repeat (8) @(posedge clk_sys);
               miiCol <= 1'b1;
               repeat (3) @(posedge clk_sys);
               miiCol <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire
